/* design/i2ctr_cfg.svh */
// constants of the two-wire target receive engine: flag positions, reset values, bit counts
`ifndef I2CTR_CFG_SVH
`define I2CTR_CFG_SVH

// -----------------------------------------------------------------------------
// sticky event flag positions
// -----------------------------------------------------------------------------
`define I2CTR_F_START   0
`define I2CTR_F_STOP    1
`define I2CTR_F_ADDR    2
`define I2CTR_F_WRITE   3
`define I2CTR_F_COUNT   4
`define I2CTR_F_NACK    5
`define I2CTR_F_SHARED  6
`define I2CTR_NFLAGS    7

// -----------------------------------------------------------------------------
// bit counts and reset values
// -----------------------------------------------------------------------------
`define I2CTR_LAST_BIT  4'h7
`define I2CTR_HOLD_BIT  4'h6
`define I2CTR_CNT_RST   8'h00
`define I2CTR_BYTE_RST  8'h00

`endif

/* design/i2ctr_pkg.sv */
// types shared by the two-wire target receive engine
`include "i2ctr_cfg.svh"
package i2ctr_pkg;

	// engine phases on the reference clock
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_ACK9,
		ST_DATA
	} i2ctr_state_t;

	// whole state of the reference-clock side
	typedef struct packed
	{
		i2ctr_state_t              st;
		logic [3:0]                bitCnt;
		logic [7:0]                shift;
		logic                      isData;
		logic                      ackLat;
		logic                      sdaPrev;
		logic                      sclPrev;
		logic                      togA;
		logic                      togB;
		logic                      stretch;
		logic                      holdRx;
		logic                      sclOe;
		logic                      sdaOe;
		logic [`I2CTR_NFLAGS-1:0]  flags;
		logic                      addrTarget;
		logic                      dirBit;
		logic                      dataNotAddr;
		logic [7:0]                addrBuf;
		logic [7:0]                rxBuf;
		logic                      rxFull;
		logic [7:0]                byteCnt;
	} i2ctr_core_t;

	// state of the link-clock side
	typedef struct packed
	{
		logic bitVal;
		logic tog;
	} i2ctr_link_t;

endpackage

/* design/i2ctr_sync.sv */
// two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
module i2ctr_sync #(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input  logic             clk,
	input  logic             rst,
	// levels from another domain and their synchronised copies
	input  logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q   <= '0;
			stable_q <= '0;
		end
		else
		begin
			meta_q   <= din;
			stable_q <= meta_q;
		end
	end

	assign dout = stable_q;

endmodule

/* design/i2ctr_target_rx.sv */
// two-wire bus target receive engine, 7-bit addressing
`timescale 1ns/100ps
`include "i2ctr_cfg.svh"
module i2ctr_target_rx
(
	// reference clock and reset
	input  logic                            ref_clk,
	input  logic                            rst,
	// bus pins; the SCL pin also clocks the bit sampler
	input  logic                            sclLink,
	input  logic                            sdaIn,
	output logic                            sclOut,
	output logic                            sclOe,
	output logic                            sdaOut,
	output logic                            sdaOe,
	// configuration
	input  logic [7:0]                      addrMatch0,
	input  logic [7:0]                      addrMatch1,
	input  logic [7:0]                      addrMatch2,
	input  logic [7:0]                      addrMatch3,
	input  logic                            startIrqEnable,
	input  logic                            addrHoldIrqEnable,
	input  logic                            ackHoldIrqEnable,
	input  logic                            dataWriteHoldIrqEnable,
	input  logic                            ackValue,
	input  logic                            endOfCountAckValue,
	input  logic                            errorPending,
	// firmware strobes, one cycle each
	input  logic [`I2CTR_NFLAGS-1:0]        flagClear,
	input  logic                            stretchClear,
	input  logic                            rxRead,
	input  logic                            byteCounterLoad,
	input  logic [7:0]                      byteCounterLoadValue,
	// status
	output logic [`I2CTR_NFLAGS-1:0]        eventFlags,
	output logic                            clockStretch,
	output logic                            addressedAsTarget,
	output logic                            dirBit,
	output logic                            dataNotAddr,
	output logic [7:0]                      addrBuffer0,
	output logic [7:0]                      rxBuffer,
	output logic                            rxBufferFull,
	output logic                            rxIrqFlag,
	output logic [7:0]                      byteCounter,
	output i2ctr_pkg::i2ctr_state_t         engineState
);
	import i2ctr_pkg::*;

	// -------------------------------------------------------------------------
	// address compare
	// -------------------------------------------------------------------------

	// low bit of each match register is unused in plain 7-bit mode
	function automatic logic addr_hit(
		input logic [7:0] rx,
		input logic [7:0] m0,
		input logic [7:0] m1,
		input logic [7:0] m2,
		input logic [7:0] m3
	);
		addr_hit = (rx[7:1] == m0[7:1]) || (rx[7:1] == m1[7:1]) ||
			(rx[7:1] == m2[7:1]) || (rx[7:1] == m3[7:1]);
	endfunction

	// -------------------------------------------------------------------------
	// link clock side
	// -------------------------------------------------------------------------

	i2ctr_link_t lk_q;
	i2ctr_link_t lk_d;

	// each rising SCL samples SDA and flips the event toggle
	always_comb
	begin
		lk_d        = lk_q;
		lk_d.bitVal = sdaIn;
		lk_d.tog    = ~lk_q.tog;
	end

	// clock may stand still between frames; only the toggle edge matters
	always_ff @(posedge sclLink or posedge rst)
	begin
		if (rst)
			lk_q <= '0;
		else
			lk_q <= lk_d;
	end

	// -------------------------------------------------------------------------
	// crossing into the reference clock
	// -------------------------------------------------------------------------

	logic [3:0] syncOut;
	logic       sclLvl;
	logic       sdaLvl;
	logic       bitLvl;
	logic       togSync;

	i2ctr_sync #(
		.WIDTH (4)
	) u_sync (
		.clk   (ref_clk),
		.rst   (rst),
		.din   ({lk_q.tog, lk_q.bitVal, sdaIn, sclLink}),
		.dout  (syncOut)
	);

	assign sclLvl  = syncOut[0];
	assign sdaLvl  = syncOut[1];
	assign bitLvl  = syncOut[2];
	assign togSync = syncOut[3];

	// -------------------------------------------------------------------------
	// reference clock engine
	// -------------------------------------------------------------------------

	i2ctr_core_t s_q;
	i2ctr_core_t s_d;
	logic        evBit;
	logic        sclFall;
	logic        startCond;
	logic        stopCond;
	logic [7:0]  byteIn;
	logic        hit;
	logic        ackBit;
	logic [`I2CTR_NFLAGS-1:0] setF;

	// event one cycle late so the sampled bit has settled beside its toggle
	assign evBit     = s_q.togA ^ s_q.togB;
	assign sclFall   = s_q.sclPrev & ~sclLvl;
	assign startCond = sclLvl & s_q.sclPrev & s_q.sdaPrev & ~sdaLvl;
	assign stopCond  = sclLvl & s_q.sclPrev & ~s_q.sdaPrev & sdaLvl;
	assign byteIn    = {s_q.shift[6:0], bitLvl};
	assign hit       = addr_hit(byteIn, addrMatch0, addrMatch1, addrMatch2, addrMatch3);

	// answer value: error forces nack on address, counter picks on data
	always_comb
	begin
		if (!s_q.isData)
			ackBit = errorPending | ackValue;
		else if (s_q.byteCnt == `I2CTR_CNT_RST)
			ackBit = endOfCountAckValue;
		else
			ackBit = ackValue;
	end

	// next state; hardware sets are applied after firmware clears so sets win
	always_comb
	begin
		s_d         = s_q;
		setF        = '0;
		s_d.togA    = togSync;
		s_d.togB    = s_q.togA;
		s_d.sdaPrev = sdaLvl;
		s_d.sclPrev = sclLvl;

		// firmware side effects
		if (rxRead)
		begin
			s_d.rxFull = 1'h0;
			if (s_q.holdRx)
			begin
				s_d.stretch = 1'h0;
				s_d.holdRx  = 1'h0;
			end
		end
		if (stretchClear)
		begin
			s_d.stretch = 1'h0;
			s_d.holdRx  = 1'h0;
		end
		if (byteCounterLoad)
			s_d.byteCnt = byteCounterLoadValue;

		case (s_q.st)
			ST_IDLE:
			begin
				s_d.sdaOe = 1'h0;
			end
			ST_ADDR:
			begin
				if (evBit)
				begin
					s_d.shift  = byteIn;
					s_d.bitCnt = s_q.bitCnt + 4'h1;
					// seven address bits then the direction bit
					if (s_q.bitCnt == `I2CTR_LAST_BIT)
					begin
						if (hit)
						begin
							s_d.addrTarget  = 1'h1;
							s_d.dirBit      = bitLvl;
							s_d.dataNotAddr = 1'h0;
							s_d.addrBuf     = byteIn;
							setF[`I2CTR_F_ADDR] = 1'h1;
							if (addrHoldIrqEnable)
							begin
								s_d.stretch = 1'h1;
								setF[`I2CTR_F_SHARED] = 1'h1;
							end
							// reads need the transmit engine; this one lets them pass
							s_d.st     = bitLvl ? ST_IDLE : ST_ACK;
							s_d.isData = 1'h0;
						end
						else
							s_d.st = ST_IDLE;
					end
				end
			end
			ST_ACK:
			begin
				// SDA only moves while SCL is low; firmware may still change the value
				if (!sclLvl)
					s_d.sdaOe = ~ackBit;
				if (evBit)
				begin
					s_d.st     = ST_ACK9;
					s_d.ackLat = ackBit;
					if (s_q.isData)
					begin
						if (s_q.byteCnt == `I2CTR_CNT_RST)
							setF[`I2CTR_F_COUNT] = 1'h1;
						else if (!byteCounterLoad)
							s_d.byteCnt = s_q.byteCnt - 8'h01;
					end
					if (ackHoldIrqEnable)
					begin
						s_d.stretch = 1'h1;
						setF[`I2CTR_F_SHARED] = 1'h1;
					end
				end
			end
			ST_ACK9:
			begin
				// answer stays on SDA until the master drops SCL
				if (sclFall)
				begin
					s_d.sdaOe  = 1'h0;
					s_d.bitCnt = 4'h0;
					if (s_q.ackLat)
					begin
						setF[`I2CTR_F_NACK] = 1'h1;
						s_d.st = ST_IDLE;
					end
					else
						s_d.st = ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (evBit)
				begin
					s_d.shift  = byteIn;
					s_d.bitCnt = s_q.bitCnt + 4'h1;
					// stall before the last bit while the old byte is unread
					if (s_q.bitCnt == `I2CTR_HOLD_BIT && s_d.rxFull)
					begin
						s_d.stretch = 1'h1;
						s_d.holdRx  = 1'h1;
					end
					if (s_q.bitCnt == `I2CTR_LAST_BIT)
					begin
						s_d.dataNotAddr = 1'h1;
						setF[`I2CTR_F_WRITE] = 1'h1;
						s_d.rxBuf  = byteIn;
						s_d.rxFull = 1'h1;
						if (dataWriteHoldIrqEnable)
						begin
							s_d.stretch = 1'h1;
							setF[`I2CTR_F_SHARED] = 1'h1;
						end
						s_d.st     = ST_ACK;
						s_d.isData = 1'h1;
					end
				end
			end
			default:
			begin
				s_d.st = ST_IDLE;
			end
		endcase

		// bus conditions override any phase
		if (startCond)
		begin
			s_d.st     = ST_ADDR;
			s_d.bitCnt = 4'h0;
			s_d.sdaOe  = 1'h0;
			setF[`I2CTR_F_START] = 1'h1;
			if (startIrqEnable)
				setF[`I2CTR_F_SHARED] = 1'h1;
		end
		if (stopCond)
		begin
			s_d.st         = ST_IDLE;
			s_d.sdaOe      = 1'h0;
			s_d.addrTarget = 1'h0;
			setF[`I2CTR_F_STOP] = 1'h1;
		end

		s_d.flags = (s_q.flags & ~flagClear) | setF;
		// grab SCL only once the master has pulled it low, never mid-high
		s_d.sclOe = s_q.stretch & (s_q.sclOe | ~sclLvl);
	end

	// one register for the whole engine
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.byteCnt <= `I2CTR_CNT_RST;
			s_q.rxBuf   <= `I2CTR_BYTE_RST;
			s_q.sdaPrev <= 1'h1;
			s_q.sclPrev <= 1'h1;
		end
		else
			s_q <= s_d;
	end

	// -------------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------------

	assign sclOut            = 1'h0;
	assign sdaOut            = 1'h0;
	assign sclOe             = s_q.sclOe;
	assign sdaOe             = s_q.sdaOe;
	assign eventFlags        = s_q.flags;
	assign clockStretch      = s_q.stretch;
	assign addressedAsTarget = s_q.addrTarget;
	assign dirBit            = s_q.dirBit;
	assign dataNotAddr       = s_q.dataNotAddr;
	assign addrBuffer0       = s_q.addrBuf;
	assign rxBuffer          = s_q.rxBuf;
	assign rxBufferFull      = s_q.rxFull;
	assign rxIrqFlag         = s_q.rxFull;
	assign byteCounter       = s_q.byteCnt;
	assign engineState       = s_q.st;

	// -------------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------------

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic addrDone;
	logic dataDone;
	logic ack9Data;
	assign addrDone = (s_q.st == ST_ADDR) && evBit && (s_q.bitCnt == `I2CTR_LAST_BIT)
		&& !startCond && !stopCond;
	assign dataDone = (s_q.st == ST_DATA) && evBit && (s_q.bitCnt == `I2CTR_LAST_BIT)
		&& !startCond && !stopCond;
	assign ack9Data = (s_q.st == ST_ACK) && evBit && s_q.isData && !startCond && !stopCond;

	a_start_flag: assert property (startCond |=> eventFlags[`I2CTR_F_START])
		else $error("start not flagged");
	a_start_shared: assert property (startCond && startIrqEnable |=> eventFlags[`I2CTR_F_SHARED])
		else $error("start did not raise shared flag");
	a_dir_copy: assert property (addrDone && hit |=> dirBit == $past(bitLvl))
		else $error("direction bit not copied");
	a_addr_match: assert property (addrDone && hit |=> addressedAsTarget && !dataNotAddr)
		else $error("match status wrong");
	a_addr_buffer: assert property (addrDone && hit |=> addrBuffer0 == $past(byteIn)
		&& eventFlags[`I2CTR_F_ADDR])
		else $error("address buffer not loaded");
	a_addr_miss: assert property (addrDone && !hit |=> engineState == ST_IDLE)
		else $error("miss did not go idle");
	a_addr_hold: assert property (addrDone && hit && addrHoldIrqEnable |=> clockStretch)
		else $error("address hold missing");
	a_error_nack: assert property ((s_q.st == ST_ACK) && !s_q.isData && errorPending && !sclLvl
		&& !startCond && !stopCond |=> !sdaOe)
		else $error("error did not force nack");
	a_ack_drive: assert property ((s_q.st == ST_ACK) && !sclLvl && !startCond && !stopCond
		|=> sdaOe == !$past(ackBit))
		else $error("ack value not on SDA");
	a_stop_idle: assert property (stopCond |=> engineState == ST_IDLE
		&& eventFlags[`I2CTR_F_STOP])
		else $error("stop not handled");
	a_rx_load: assert property (dataDone |=> rxBufferFull && rxBuffer == $past(byteIn)
		&& dataNotAddr && eventFlags[`I2CTR_F_WRITE])
		else $error("received byte not loaded");
	a_rx_hold: assert property ((s_q.st == ST_DATA) && evBit && (s_q.bitCnt == `I2CTR_HOLD_BIT)
		&& rxBufferFull && !rxRead && !startCond && !stopCond |=> clockStretch)
		else $error("full buffer did not stretch");
	a_count_zero: assert property (ack9Data && byteCounter == 8'h00 |=> eventFlags[`I2CTR_F_COUNT])
		else $error("count reached not flagged");
	a_count_dec: assert property (ack9Data && byteCounter != 8'h00 && !byteCounterLoad
		|=> byteCounter == $past(byteCounter) - 8'h01)
		else $error("byte counter not decremented");
	a_nack_idle: assert property ((s_q.st == ST_ACK9) && s_q.ackLat && sclFall && !startCond
		&& !stopCond |=> engineState == ST_IDLE && eventFlags[`I2CTR_F_NACK])
		else $error("nack not flagged");
	a_stretch_hold: assert property (clockStretch && sclOe |=> sclOe)
		else $error("SCL released while stretching");

	c_addr_match: cover property (addrDone && hit);
	c_data_byte: cover property (dataDone);
	c_rx_stall: cover property (s_q.holdRx && sclOe);
	c_nack_sent: cover property (eventFlags[`I2CTR_F_NACK]);

endmodule

/* test/i2ctr_master_model.sv */
// bus master model that drives the two-wire link of the target receive engine
`timescale 1ns/100ps
module i2ctr_master_model
(
	// pin enables of the target
	input  wire logic sclOe,
	input  wire logic sdaOe,
	// wired bus levels, both pulled up
	output wire logic sclWire,
	output wire logic sdaWire
);
	logic sclLow;
	logic sdaLow;
	logic timedOut;

	// open drain: whoever pulls low wins, released lines float to the pull-up
	assign sclWire = ~(sclLow | sclOe);
	assign sdaWire = ~(sdaLow | sdaOe);

	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
		timedOut = 1'b0;
	end

	// release SCL and wait out a stretch; bounded so a stuck target cannot hang us
	task automatic rise();
		int i;
		sclLow = 1'b0;
		for (i = 0; i < 20000 && !sclWire; i++)
			#1;
		if (!sclWire)
			timedOut = 1'b1;
		#16;
	endtask

	// start or repeated start: SDA falls while SCL is high
	task automatic start_cond();
		#3.3;
		sdaLow = 1'b0;
		#16;
		rise();
		sdaLow = 1'b1;
		#16;
		sclLow = 1'b1;
	endtask

	// stop: SDA rises while SCL is high; SCL then stands still high
	task automatic stop_cond();
		sdaLow = 1'b1;
		#48;
		rise();
		sdaLow = 1'b0;
		#16;
	endtask

	// eight bits then the ninth pulse; answer sampled late in the high phase
	// low phase held for 48 ns, six reference periods: the target moves SDA only after
	// its synchronisers have seen SCL low, which takes a few reference cycles
	task automatic send_byte(input logic [7:0] b, output logic ack);
		int k;
		for (k = 7; k >= 0; k--)
		begin
			sdaLow = ~b[k];
			#48;
			rise();
			sclLow = 1'b1;
		end
		sdaLow = 1'b0;
		#48;
		rise();
		ack = sdaWire;
		sclLow = 1'b1;
	endtask
endmodule

/* test/i2ctr_target_rx_bench.sv */
// self-checking bench of the two-wire target receive engine
`timescale 1ns/100ps
`include "i2ctr_cfg.svh"
module i2ctr_target_rx_bench;
	import i2ctr_pkg::*;
	logic                     ref_clk, rst, sclOe, sdaOe, sclWire, sdaWire;
	logic [7:0]               addrMatch0, addrMatch1, addrMatch2, addrMatch3;
	logic                     startIrqEnable, addrHoldIrqEnable, ackHoldIrqEnable;
	logic                     dataWriteHoldIrqEnable, ackValue, endOfCountAckValue;
	logic                     errorPending, stretchClear, rxRead, byteCounterLoad;
	logic [`I2CTR_NFLAGS-1:0] flagClear, eventFlags;
	logic [7:0]               byteCounterLoadValue, addrBuffer0, rxBuffer, byteCounter;
	logic                     clockStretch, addressedAsTarget, dirBit, dataNotAddr;
	logic                     rxBufferFull, rxIrqFlag, a, done;
	i2ctr_state_t             engineState;
	int                       fails = 0;
	int                       cmp_count = 0;

	i2ctr_target_rx i2ctr_target_rx_inst (.ref_clk(ref_clk), .rst(rst), .sclLink(sclWire),
		.sdaIn(sdaWire), .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe),
		.addrMatch0(addrMatch0), .addrMatch1(addrMatch1), .addrMatch2(addrMatch2),
		.addrMatch3(addrMatch3), .startIrqEnable(startIrqEnable),
		.addrHoldIrqEnable(addrHoldIrqEnable), .ackHoldIrqEnable(ackHoldIrqEnable),
		.dataWriteHoldIrqEnable(dataWriteHoldIrqEnable), .ackValue(ackValue),
		.endOfCountAckValue(endOfCountAckValue), .errorPending(errorPending),
		.flagClear(flagClear), .stretchClear(stretchClear), .rxRead(rxRead),
		.byteCounterLoad(byteCounterLoad), .byteCounterLoadValue(byteCounterLoadValue),
		.eventFlags(eventFlags), .clockStretch(clockStretch),
		.addressedAsTarget(addressedAsTarget), .dirBit(dirBit), .dataNotAddr(dataNotAddr),
		.addrBuffer0(addrBuffer0), .rxBuffer(rxBuffer), .rxBufferFull(rxBufferFull),
		.rxIrqFlag(rxIrqFlag), .byteCounter(byteCounter), .engineState(engineState));
	i2ctr_master_model i2ctr_master_model_inst (.sclOe(sclOe), .sdaOe(sdaOe),
		.sclWire(sclWire), .sdaWire(sdaWire));

	// 125 MHz reference clock
	always #4 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// one-cycle firmware strobe, launched just after an edge
	task automatic pulse(ref logic s);
		@(posedge ref_clk);
		#1 s = 1'b1;
		@(posedge ref_clk);
		#1 s = 1'b0;
	endtask

	task automatic clr();
		@(posedge ref_clk);
		#1 flagClear = '1;
		@(posedge ref_clk);
		#1 flagClear = '0;
	endtask

	task automatic load_cnt(input logic [7:0] v);
		byteCounterLoadValue = v;
		pulse(byteCounterLoad);
	endtask

	// lets the synchronisers and the engine catch up with the pins
	task automatic settle();
		repeat (8) @(posedge ref_clk);
		#1;
	endtask

	// bounded wait for a stretch; gives up after 4000 cycles or once done is set, without counting a mismatch
	task automatic wait_stretch();
		int i;
		for (i = 0; i < 4000 && !clockStretch && !done; i++)
			@(posedge ref_clk);
		#1;
	endtask

	// ---------------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------------
	task automatic t_write();
		clr();
		load_cnt(8'h02);
		i2ctr_master_model_inst.start_cond();
		i2ctr_master_model_inst.send_byte(8'h5a, a);
		settle();
		check("addrAck", a, 0);
		check("startFlag", eventFlags[`I2CTR_F_START], 1);
		check("addressed", addressedAsTarget, 1);
		check("dirWrite", dirBit, 0);
		check("dataIndA", dataNotAddr, 0);
		check("addrBuf", addrBuffer0, 8'h5a);
		check("addrFlag", eventFlags[`I2CTR_F_ADDR], 1);
		i2ctr_master_model_inst.send_byte(8'hc3, a);
		settle();
		check("dataAck", a, 0);
		check("rxBuf", rxBuffer, 8'hc3);
		check("rxFull", rxBufferFull, 1);
		check("rxIrq", rxIrqFlag, 1);
		check("wrFlag", eventFlags[`I2CTR_F_WRITE], 1);
		check("dataIndD", dataNotAddr, 1);
		check("count", byteCounter, 8'h01);
		pulse(rxRead);
		#1 check("rxFree", rxBufferFull, 0);
		i2ctr_master_model_inst.stop_cond();
		settle();
		check("stopFlag", eventFlags[`I2CTR_F_STOP], 1);
		check("idleStop", engineState, ST_IDLE);
		$display("t_write done");
	endtask

	// each match register, a miss and a read request, then a pending error
	task automatic t_addr();
		int k;
		logic [7:0] adr [6] = '{8'h20, 8'h42, 8'h5a, 8'h7e, 8'h10, 8'h43};
		for (k = 0; k < 6; k++)
		begin
			clr();
			i2ctr_master_model_inst.start_cond();
			i2ctr_master_model_inst.send_byte(adr[k], a);
			settle();
			check("matchAck", a, k >= 4);
			check("matchSt", addressedAsTarget, k != 4);
			if (k == 5)
				check("dirRead", dirBit, 1);
			i2ctr_master_model_inst.stop_cond();
		end
		clr();
		errorPending = 1'b1;
		i2ctr_master_model_inst.start_cond();
		i2ctr_master_model_inst.send_byte(8'h20, a);
		settle();
		check("errAck", a, 1);
		check("errNack", eventFlags[`I2CTR_F_NACK], 1);
		check("errIdle", engineState, ST_IDLE);
		i2ctr_master_model_inst.stop_cond();
		errorPending = 1'b0;
		$display("t_addr done");
	endtask

	task automatic t_count();
		clr();
		load_cnt(8'h00);
		endOfCountAckValue = 1'b1;
		i2ctr_master_model_inst.start_cond();
		i2ctr_master_model_inst.send_byte(8'h42, a);
		i2ctr_master_model_inst.send_byte(8'h99, a);
		settle();
		check("eocAck", a, 1);
		check("cntFlag", eventFlags[`I2CTR_F_COUNT], 1);
		check("nackFlag", eventFlags[`I2CTR_F_NACK], 1);
		check("nackIdle", engineState, ST_IDLE);
		i2ctr_master_model_inst.stop_cond();
		endOfCountAckValue = 1'b0;
		pulse(rxRead);
		$display("t_count done");
	endtask

	// every hold enabled; firmware services each stretch but the last acknowledge hold in parallel
	task automatic t_hold();
		int n = 0;
		clr();
		load_cnt(8'h04);
		{startIrqEnable, addrHoldIrqEnable, dataWriteHoldIrqEnable, ackHoldIrqEnable} = '1;
		done = 1'b0;
		fork
		begin
			i2ctr_master_model_inst.start_cond();
			settle();
			check("startIrq", eventFlags[`I2CTR_F_SHARED], 1);
			// clear so each hold must raise the shared flag by itself
			clr();
			i2ctr_master_model_inst.send_byte(8'h7e, a);
			i2ctr_master_model_inst.send_byte(8'h3c, a);
			done = 1'b1;
		end
		while (!done)
		begin
			wait_stretch();
			if (clockStretch && !done)
			begin
				settle();
				check("holdScl", sclOe, 1);
				check("holdIrq", eventFlags[`I2CTR_F_SHARED], 1);
				clr();
				pulse(stretchClear);
				n++;
			end
		end
		join
		// the last acknowledge hold comes after the master is done; serve it here
		settle();
		check("holdAckSt", clockStretch, 1);
		check("holdAck", a, 0);
		pulse(stretchClear);
		check("holdCnt", n >= 3, 1);
		check("holdRx", rxBuffer, 8'h3c);
		{startIrqEnable, addrHoldIrqEnable, dataWriteHoldIrqEnable, ackHoldIrqEnable} = '0;
		pulse(rxRead);
		i2ctr_master_model_inst.stop_cond();
		$display("t_hold done");
	endtask

	// second byte arrives while the first is still unread
	task automatic t_full();
		clr();
		load_cnt(8'h05);
		done = 1'b0;
		i2ctr_master_model_inst.start_cond();
		i2ctr_master_model_inst.send_byte(8'h7e, a);
		i2ctr_master_model_inst.send_byte(8'h11, a);
		fork
			i2ctr_master_model_inst.send_byte(8'h22, a);
		begin
			wait_stretch();
			settle();
			check("fullScl", sclOe, 1);
			check("fullOld", rxBuffer, 8'h11);
			pulse(rxRead);
		end
		join
		settle();
		check("fullNew", rxBuffer, 8'h22);
		check("fullAck", a, 0);
		check("fullCnt", byteCounter, 8'h03);
		pulse(rxRead);
		i2ctr_master_model_inst.stop_cond();
		$display("t_full done");
	endtask

	initial
	begin
		{ref_clk, rst, flagClear, stretchClear, rxRead, byteCounterLoad} = '0;
		{startIrqEnable, addrHoldIrqEnable, dataWriteHoldIrqEnable, ackHoldIrqEnable} = '0;
		{ackValue, endOfCountAckValue, errorPending, byteCounterLoadValue, done} = '0;
		{addrMatch0, addrMatch1, addrMatch2, addrMatch3} = {8'h20, 8'h42, 8'h5a, 8'h7e};
		rst = 1'b1;
		repeat (16) @(posedge ref_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		t_write();
		t_addr();
		t_count();
		t_hold();
		t_full();
		check("busHang", i2ctr_master_model_inst.timedOut, 0);
		stop_test();
	end
endmodule
